/* File: verilog/spsp_serial_port.v */
`include "spsp_map.vh"
`default_nettype none

// Notes on behaviour
// - low chip select opens a transfer; serial clock shifts data both ways
// - chip select rising edge moves shifted bits into the instruction byte
// - byte bits 3..0 select target, bits 7..4 carry payload nibble
// - a 16-bit value needs four bytes, one nibble each
// - input arrives target lsb first, payload msb last
// - target nibble routes payload to holding, pointer, command or mode
// - all readout comes from the holding word, loaded by internal operations
// - sixteen serial clocks shift the holding word out msb first
// - four-wire: shift in while out; last eight bits are decoded
// - three-wire enable drives output for the next select period only
// - three-wire inputs accepted except in a frame the port reads out; output idle until enabled
// - command target writes decode payload and start the command unless flash is busy
// - after reset: three-wire, receive only, output released
// - non-flash commands finish within 4us of select rise
// - flash program needs 80us, erase 4.2ms before next command
// - three-wire in and out may share one line
// - four-wire mode enables the output in every select-low period, no per-read enable

module spsp_serial_port #(
	parameter BUSY_WIDTH = 24,
	parameter PROG_CYCLES = (`SPSP_PROG_NS + `SPSP_CLK_PERIOD_NS - 1) /
		`SPSP_CLK_PERIOD_NS,
	parameter ERASE_CYCLES = (`SPSP_ERASE_NS + `SPSP_CLK_PERIOD_NS - 1) /
		`SPSP_CLK_PERIOD_NS
) (
	input wire ref_clk,
	input wire resetn,
	input wire clkEn,
	input wire selectN,
	input wire serialClk,
	input wire serial_in,
	input wire holdLoad,
	input wire [15:0] holdLoadData,
	output reg serialOut,
	output reg serialOutEn,
	output reg [7:0] instr_shift_byte,
	output reg [15:0] holding_word_reg,
	output reg [15:0] pointer_reg,
	output reg [3:0] command_reg,
	output reg cmdStrobe,
	output reg fourWire,
	output reg flashBusy
);
	// ==========================================================
	// reset release
	reg rstMeta;
	reg rstn;
	// asserts at once, releases on the clock so no flop sees a runt reset
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rstMeta <= 1'b0;
			rstn <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstn <= rstMeta;
		end
	end

	// ==========================================================
	// pin synchronisers and edge detect
	// select enters inverted so the flop reset value matches an idle pin
	wire [2:0] pinSync;
	wire selSync = ~pinSync[0];
	wire clkSync = pinSync[1];
	wire dinSync = pinSync[2];
	reg selPrev;
	reg clkPrev;

	spsp_sync #(
		.WIDTH(3)
	) uSync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.clkEn(clkEn),
		.asyncIn({serial_in, serialClk, ~selectN}),
		.syncOut(pinSync)
	);

	// history flops read only synchronised copies
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			selPrev <= 1'b1;
			clkPrev <= 1'b0;
		end else if (clkEn) begin
			selPrev <= selSync;
			clkPrev <= clkSync;
		end
	end

	// serial clock edges only count inside a frame
	wire selFall = selPrev & ~selSync;
	wire selRise = ~selPrev & selSync;
	wire selLow = ~selSync;
	wire sclkRise = selLow & ~clkPrev & clkSync;
	wire sclkFall = selLow & clkPrev & ~clkSync;

	// ==========================================================
	// input shifter
	reg [7:0] inShift;
	reg [4:0] bitCount;
	reg outArmed;
	reg outThisFrame;

	// new bits enter at the top so the first bit ends at bit 0
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			inShift <= `SPSP_INSTR_RST;
			bitCount <= 5'h00;
		end else if (clkEn) begin
			if (selFall) begin
				bitCount <= 5'h00;
			end else if (sclkRise) begin
				inShift <= {dinSync, inShift[7:1]};
				if (bitCount != 5'h1F) begin
					bitCount <= bitCount + 5'h01;
				end
			end
		end
	end

	// a short frame or our own three-wire readout is not an instruction
	wire byteGood = (bitCount >= `SPSP_BITS_PER_BYTE) &
		~(outThisFrame & ~fourWire);
	wire [3:0] tgtNib = inShift[`SPSP_TGT_MSB:`SPSP_TGT_LSB];
	wire [3:0] payNib = inShift[`SPSP_PAY_MSB:`SPSP_PAY_LSB];
	wire decodeNow = selRise & byteGood;

	// ==========================================================
	// instruction byte
	// last accepted byte, kept for observation
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			instr_shift_byte <= `SPSP_INSTR_RST;
		end else if (clkEn && decodeNow) begin
			instr_shift_byte <= inShift;
		end
	end

	// ==========================================================
	// holding word
	wire holdNibWr = decodeNow & (tgtNib <= `SPSP_TGT_HOLD3);

	// serial nibble beats the internal load in the same cycle
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			holding_word_reg <= `SPSP_HOLD_RST;
		end else if (clkEn) begin
			if (holdNibWr) begin
				// one nibble per byte, four bytes per word
				holding_word_reg[tgtNib[1:0]*4 +: 4] <= payNib;
			end else if (holdLoad) begin
				holding_word_reg <= holdLoadData;
			end
		end
	end

	// ==========================================================
	// pointer word
	wire ptrNibWr = decodeNow & (tgtNib >= `SPSP_TGT_PTR0) &
		(tgtNib <= `SPSP_TGT_PTR3);

	// pointer only changes nibble by nibble from the link
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pointer_reg <= `SPSP_PTR_RST;
		end else if (clkEn && ptrNibWr) begin
			pointer_reg[tgtNib[1:0]*4 +: 4] <= payNib;
		end
	end

	// ==========================================================
	// command register and flash busy timer
	reg [BUSY_WIDTH-1:0] busyCount;
	reg [BUSY_WIDTH-1:0] next_busyCount;
	reg next_flashBusy;
	wire cmdWrite = decodeNow & (tgtNib == `SPSP_TGT_CMD) & ~flashBusy;
	wire progStart = cmdWrite & (payNib == `SPSP_CMD_PROG);
	wire eraseStart = cmdWrite & ((payNib == `SPSP_CMD_PAGE_ERASE) |
		(payNib == `SPSP_CMD_ALL_ERASE));

	// commands during a flash operation are dropped, not queued
	always @* begin
		next_flashBusy = flashBusy;
		next_busyCount = busyCount;
		if (progStart) begin
			next_flashBusy = 1'b1;
			next_busyCount = PROG_CYCLES[BUSY_WIDTH-1:0] - 1'b1;
		end else if (eraseStart) begin
			next_flashBusy = 1'b1;
			next_busyCount = ERASE_CYCLES[BUSY_WIDTH-1:0] - 1'b1;
		end else if (flashBusy) begin
			if (busyCount == {BUSY_WIDTH{1'b0}}) begin
				next_flashBusy = 1'b0;
			end else begin
				next_busyCount = busyCount - 1'b1;
			end
		end
	end

	// strobe is a single-cycle pulse per accepted command
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			command_reg <= 4'h0;
			cmdStrobe <= 1'b0;
			flashBusy <= 1'b0;
			busyCount <= {BUSY_WIDTH{1'b0}};
		end else if (clkEn) begin
			cmdStrobe <= cmdWrite;
			if (cmdWrite) begin
				command_reg <= payNib;
			end
			flashBusy <= next_flashBusy;
			busyCount <= next_busyCount;
		end
	end

	// ==========================================================
	// link mode and output arming
	wire modeWrite = decodeNow & (tgtNib == `SPSP_TGT_MODE);
	wire fourCmd = modeWrite & (payNib == `SPSP_MODE_FOUR);
	wire threeCmd = modeWrite & (payNib == `SPSP_MODE_THREE);
	reg next_fourWire;
	reg next_outArmed;
	reg next_outThisFrame;

	// arming lasts exactly one select-low period
	always @* begin
		next_fourWire = fourWire;
		next_outArmed = outArmed;
		next_outThisFrame = outThisFrame;
		if (fourCmd) begin
			next_fourWire = 1'b1;
			next_outArmed = 1'b0;
		end else if (threeCmd) begin
			next_fourWire = 1'b0;
			next_outArmed = 1'b1;
		end else if (selFall) begin
			next_outArmed = 1'b0;
		end
		if (selFall) begin
			next_outThisFrame = outArmed;
		end else if (selRise) begin
			next_outThisFrame = 1'b0;
		end
	end

	// reset leaves the output released in three-wire receive mode
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			fourWire <= 1'b0;
			outArmed <= 1'b0;
			outThisFrame <= 1'b0;
		end else if (clkEn) begin
			fourWire <= next_fourWire;
			outArmed <= next_outArmed;
			outThisFrame <= next_outThisFrame;
		end
	end

	// ==========================================================
	// output shifter
	reg [15:0] outShift;
	reg [15:0] next_outShift;
	reg next_serialOut;
	wire next_serialOutEn;

	// load at select fall, advance on falling serial clock for host sampling
	always @* begin
		next_outShift = outShift;
		next_serialOut = serialOut;
		if (selFall) begin
			next_outShift = holding_word_reg;
			next_serialOut = holding_word_reg[15];
		end else if (sclkFall) begin
			next_outShift = {outShift[14:0], 1'b0};
			next_serialOut = outShift[14];
		end
	end

	// three-wire shared line released the moment select rises
	assign next_serialOutEn = selLow & ~selRise & (fourWire |
		(selFall ? outArmed : outThisFrame));

	// every port output comes straight from a flop
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			outShift <= `SPSP_HOLD_RST;
			serialOut <= 1'b0;
			serialOutEn <= 1'b0;
		end else if (clkEn) begin
			outShift <= next_outShift;
			serialOut <= next_serialOut;
			serialOutEn <= next_serialOutEn;
		end
	end
endmodule // spsp_serial_port

`default_nettype wire

/* File: verilog/spsp_map.vh */
`ifndef SPSP_MAP_VH
`define SPSP_MAP_VH

// ==========================================================
// target select nibble decode
`define SPSP_TGT_HOLD0 4'h0
`define SPSP_TGT_HOLD1 4'h1
`define SPSP_TGT_HOLD2 4'h2
`define SPSP_TGT_HOLD3 4'h3
`define SPSP_TGT_PTR0 4'h4
`define SPSP_TGT_PTR1 4'h5
`define SPSP_TGT_PTR2 4'h6
`define SPSP_TGT_PTR3 4'h7
`define SPSP_TGT_CMD 4'h8
`define SPSP_TGT_MODE 4'h9

// ==========================================================
// instruction byte fields
`define SPSP_TGT_LSB 0
`define SPSP_TGT_MSB 3
`define SPSP_PAY_LSB 4
`define SPSP_PAY_MSB 7

// ==========================================================
// mode payloads and flash commands
`define SPSP_MODE_FOUR 4'h0
`define SPSP_MODE_THREE 4'h1
`define SPSP_CMD_PROG 4'h1
`define SPSP_CMD_PAGE_ERASE 4'hD
`define SPSP_CMD_ALL_ERASE 4'hE

// ==========================================================
// reset values
`define SPSP_HOLD_RST 16'h0000
`define SPSP_PTR_RST 16'h0000
`define SPSP_INSTR_RST 8'h00

// ==========================================================
// timing
`define SPSP_CLK_PERIOD_NS 5
`define SPSP_PROG_NS 80000
`define SPSP_ERASE_NS 4200000
`define SPSP_CMD_LIMIT_NS 4000
`define SPSP_BITS_PER_BYTE 8

`endif

/* File: verilog/spsp_sync.v */
`default_nettype none

// ==========================================================
// two-stage synchroniser, one per bit
module spsp_sync #(
	parameter WIDTH = 3
) (
	input wire ref_clk,
	input wire rstn,
	input wire clkEn,
	input wire [WIDTH-1:0] asyncIn,
	output wire [WIDTH-1:0] syncOut
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : gBit
			reg meta;
			reg stable;
			// first stage feeds only the second
			always @(posedge ref_clk or negedge rstn) begin
				if (!rstn) begin
					meta <= 1'b0;
					stable <= 1'b0;
				end else if (clkEn) begin
					meta <= asyncIn[i];
					stable <= meta;
				end
			end
			assign syncOut[i] = stable;
		end
	endgenerate
endmodule // spsp_sync

`default_nettype wire

/* File: sim/spsp_host.sv */
`default_nettype none
// ==========================================================
// host model: drives select, serial clock and data
module spsp_host (
	input wire logic ref_clk,
	input wire logic serialOut,
	input wire logic serialOutEn,
	output var logic selectN,
	output var logic serialClk,
	output var logic serialIn
);
	timeunit 1ns;
	timeprecision 100ps;
	// clock stands still low between frames
	initial begin
		selectN = 1'b1;
		serialClk = 1'b0;
		serialIn = 1'b0;
	end
	// n clocks, data lsb first, readout taken msb first
	task automatic xfer(input logic [15:0] d, input int n,
		output logic [15:0] q, output logic en);
		q = 16'h0000;
		en = 1'b0;
		@(posedge ref_clk);
		#1 selectN = 1'b0;
		#48;
		for (int i = 0; i < n; i++) begin
			serialIn = d[i];
			en = en | serialOutEn;
			#24 serialClk = 1'b1;
			q = {q[14:0], serialOut};
			#24 serialClk = 1'b0;
		end
		#24 selectN = 1'b1;
		serialIn = ~serialIn; // no stale level once released
		#200;
	endtask
endmodule // spsp_host
`default_nettype wire

/* File: sim/spsp_props.sv */
`default_nettype none
// ==========================================================
// port checker
module spsp_props (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic selectN,
	input wire logic serialOutEn,
	input wire logic [7:0] instr_shift_byte,
	input wire logic [3:0] command_reg,
	input wire logic cmdStrobe,
	input wire logic fourWire,
	input wire logic flashBusy
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	property p_pulse;
		cmdStrobe |=> !cmdStrobe;
	endproperty
	a_pulse: assert property (p_pulse) else $error("strobe too long");
	property p_sync;
		cmdStrobe |-> selectN && $past(selectN, 3);
	endproperty
	a_sync: assert property (p_sync) else $error("decode too early");
	property p_map;
		cmdStrobe |-> instr_shift_byte == {command_reg, 4'h8};
	endproperty
	a_map: assert property (p_map) else $error("command routing");
	property p_latch;
		$changed(instr_shift_byte) |-> selectN;
	endproperty
	a_latch: assert property (p_latch) else $error("byte in frame");
	property p_en;
		$rose(serialOutEn) |-> !selectN && !$past(selectN, 2);
	endproperty
	a_en: assert property (p_en) else $error("drive out of frame");
	property p_off;
		selectN [*4] |=> !serialOutEn;
	endproperty
	a_off: assert property (p_off) else $error("output not released");
	property p_mode;
		$changed(fourWire) |-> selectN;
	endproperty
	a_mode: assert property (p_mode) else $error("mode in frame");
	property p_busy;
		$rose(flashBusy) |-> cmdStrobe || $past(cmdStrobe);
	endproperty
	a_busy: assert property (p_busy) else $error("busy no cmd");
	property p_hold;
		$rose(flashBusy) |=> flashBusy [*8];
	endproperty
	a_hold: assert property (p_hold) else $error("busy too short");
endmodule // spsp_props
bind spsp_serial_port spsp_props u_spsp_props (.ref_clk, .resetn, .selectN,
	.serialOutEn, .instr_shift_byte, .command_reg, .cmdStrobe, .fourWire,
	.flashBusy);
`default_nettype wire

/* File: sim/tb_top.sv */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0, resetn = 1'b0, holdLoad = 1'b0;
	logic [15:0] holdLoadData = 16'h0000, q;
	logic e, selectN, serialClk, hostIn, serialOut, serialOutEn;
	logic cmdStrobe, fourWire, flashBusy;
	logic tiedLines = 1'b1;
	logic [7:0] instr_shift_byte;
	logic [15:0] holding_word_reg, pointer_reg;
	logic [3:0] command_reg;
	wire serialLine;
	int n_errors = 0, num_checks = 0;
	always #2.5 ref_clk = ~ref_clk;
	// shared line in three-wire: host lets go while the port drives
	// four-wire keeps separate in and out wires
	assign serialLine = (tiedLines && serialOutEn) ? serialOut : hostIn;
	spsp_serial_port #(.PROG_CYCLES(400), .ERASE_CYCLES(800))
		u_spsp_serial_port (.ref_clk(ref_clk), .resetn(resetn),
		.clkEn(1'b1), .selectN(selectN), .serialClk(serialClk),
		.serial_in(serialLine), .holdLoad(holdLoad),
		.holdLoadData(holdLoadData), .serialOut(serialOut),
		.serialOutEn(serialOutEn), .instr_shift_byte(instr_shift_byte),
		.holding_word_reg(holding_word_reg), .pointer_reg(pointer_reg),
		.command_reg(command_reg), .cmdStrobe(cmdStrobe),
		.fourWire(fourWire), .flashBusy(flashBusy));
	spsp_host u_spsp_host (.ref_clk(ref_clk), .serialOut(serialOut),
		.serialOutEn(serialOutEn), .selectN(selectN),
		.serialClk(serialClk), .serialIn(hostIn));
	task automatic chk(input bit ok, input string m);
		num_checks++;
		if (!ok) begin
			n_errors++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask
	task automatic wr(input logic [7:0] b);
		u_spsp_host.xfer({8'h00, b}, 8, q, e);
	endtask
	task automatic wrap_up;
		if (n_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_write;
		wr(8'h30); wr(8'hC1); wr(8'h52); wr(8'hA3);
		chk(holding_word_reg === 16'hA5C3, "holding");
		wr(8'h74); wr(8'h65); wr(8'h56); wr(8'h47);
		chk(pointer_reg === 16'h4567, "pointer");
		u_spsp_host.xfer(16'h00F0, 7, q, e);
		chk(instr_shift_byte === 8'h47, "short frame");
	endtask
	task automatic t_three;
		u_spsp_host.xfer(16'h0F00, 16, q, e);
		chk(e === 1'b0, "drive unarmed");
		wr(8'h19);
		u_spsp_host.xfer(16'h0000, 16, q, e);
		chk(q === 16'hA5C3 && e === 1'b1, "3w read");
		u_spsp_host.xfer(16'h0000, 16, q, e);
		chk(e === 1'b0 && fourWire === 1'b0, "3w rearm");
	endtask
	task automatic t_four;
		tiedLines = 1'b0;
		@(posedge ref_clk);
		#1 holdLoadData = 16'h3C96;
		holdLoad = 1'b1;
		@(posedge ref_clk);
		#1 holdLoad = 1'b0;
		wr(8'h09);
		u_spsp_host.xfer(16'h5200, 16, q, e);
		chk(q === 16'h3C96 && instr_shift_byte === 8'h52, "4w");
		u_spsp_host.xfer(16'h0000, 16, q, e);
		chk(q === 16'h3596 && e === 1'b1, "4w again");
	endtask
	task automatic t_cmd;
		wr(8'h18);
		chk(command_reg === 4'h1 && flashBusy === 1'b1, "prog");
		wr(8'h28);
		chk(command_reg === 4'h1, "cmd while busy");
		for (int i = 0; i < 1000 && flashBusy !== 1'b0; i++)
			@(posedge ref_clk);
		chk(flashBusy === 1'b0, "prog stuck");
		wr(8'h28);
		chk(command_reg === 4'h2, "cmd after busy");
		wr(8'hD8);
		chk(command_reg === 4'hD && flashBusy === 1'b1, "erase");
		wr(8'h18);
		chk(command_reg === 4'hD, "cmd while erasing");
		for (int i = 0; i < 1000 && flashBusy !== 1'b0; i++)
			@(posedge ref_clk);
		chk(flashBusy === 1'b0, "erase stuck");
	endtask
	// watchdog, well beyond the expected run
	initial begin
		#200us;
		n_errors++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		#1 resetn = 1'b1;
		repeat (10) @(posedge ref_clk);
		chk(holding_word_reg === 16'h0000 && serialOutEn === 1'b0, "rst");
		chk(fourWire === 1'b0, "rst mode");
		t_write();
		t_three();
		t_four();
		t_cmd();
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
